// >>> logic/wwd_pkg.sv
package wwd_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_WINDOW = 8'h08;
	localparam logic [7:0] OFF_SERVICE = 8'h0c;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_PRESCALE_BIT = 1;
	localparam int CTRL_WIN_EN_BIT = 2;
	localparam int STAT_PREWARN_BIT = 0;
	localparam int STAT_NMI_BIT = 1;
	localparam int STAT_SYSRST_BIT = 2;
	localparam int STAT_PWCNT_LSB = 8;
	localparam int EVT_TIMEOUT_BIT = 0;
	localparam int EVT_WINDOW_BIT = 1;
	localparam int EVT_SYSRST_BIT = 2;
	localparam int EVT_W = 3;

	// ----------------------------------------------------------------
	// Counting constants
	// ----------------------------------------------------------------
	localparam logic [6:0] PRE_LAST_FAST = 7'h01;
	localparam logic [6:0] PRE_LAST_SLOW = 7'h7f;
	localparam logic [7:0] LOW_CLEAR = 8'h00;
	localparam logic [15:0] CNT_TOP = 16'hffff;
	localparam int PREWARN_COUNTS = 32'h30;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		WWD_RUN = 2'b00,
		WWD_PREWARN = 2'b01,
		WWD_SYSRST = 2'b11
	} wwd_mode_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic enable;
		logic count_prescale_select;
		logic win_en;
		logic [7:0] reload_high_byte;
		logic [7:0] window_boundary_byte;
		logic [15:0] watchdog_counter;
		logic [6:0] pre;
		wwd_mode_type mode;
		logic [7:0] pw_cnt;
		logic timeout_nmi_out;
		logic system_reset_out;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic irq;
	} wwd_state_type;

endpackage

// >>> logic/wwd_top.sv
// Operation
// R1: Counter is two chained 8-bit stages.
// R2: Count at pclk/2 or pclk/128.
// R3: Service loads reload byte, clears low.
// R4: Resume counting from reload times 256.
// R5: Overflow raises timeout NMI, enters prewarning.
// R6: Prewarning lasts 30 hex counts, then reset.
// R7: Service inside window enters prewarning, no NMI.
// R8: Window spans 0000 up to window byte:00.
// R9: Window byte above reload shortens period.
// R10: Period equals prescale times remaining counts.
// R11: Debug mode freezes watchdog entirely.
// R12: Software keeps window byte at least reload.
// R13: Each service is one single-cycle access.
// R14: Service outside window is valid, no prewarning.
module wwd_top #(
	parameter int ADDR_W = 8,
	parameter int PW_COUNTS = wwd_pkg::PREWARN_COUNTS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Debug suspend
	input wire logic debug_mode,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Watchdog outputs
	output logic timeout_nmi_out,
	output logic system_reset_out,
	output logic irq
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 8)
	begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 8");
	end
	if (PW_COUNTS < 1 || PW_COUNTS > 256)
	begin : g_bad_pw
		$error("PW_COUNTS must lie between 1 and 256");
	end

	localparam logic [7:0] PW_LAST = 8'(PW_COUNTS - 1);

	// Word-aligned offset inside the map, upper bits zero
	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr[1:0] == 2'b00) && (addr[7:5] == 3'b000);
	endfunction

	wwd_pkg::wwd_state_type st_ff;
	wwd_pkg::wwd_state_type nxt_st;
	logic run_en;
	logic tick;
	logic wr_fire;
	logic svc_req;
	logic in_window;
	logic svc_ok;
	logic win_bad;
	logic ovf;
	logic pw_done;
	logic [2:0] evt_set;
	logic [2:0] evt_clr;
	logic [7:0] ar8;
	logic [7:0] aw8;

	assign ar8 = 8'(s_axi_araddr);
	assign aw8 = 8'(s_axi_awaddr);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// All state advances from one copy; the bus and the counter share it
	always_comb
	begin
		nxt_st = st_ff;
		evt_set = 3'h0;
		evt_clr = 3'h0;

		// Suspended in debug and once reset is issued
		// R11: debug freeze
		run_en = st_ff.enable && !debug_mode && (st_ff.mode != wwd_pkg::WWD_SYSRST);

		// Compare with >= so a divider change mid-period cannot stall
		// R2: rate select
		tick = run_en && (st_ff.pre >= (st_ff.count_prescale_select ?
			wwd_pkg::PRE_LAST_SLOW : wwd_pkg::PRE_LAST_FAST));

		wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
		// R13: one write is one service
		svc_req = wr_fire && (st_ff.aw_addr == wwd_pkg::OFF_SERVICE) && (st_ff.wstrb != 4'h0);
		// R8: window range
		in_window = st_ff.win_en &&
			(st_ff.watchdog_counter <= {st_ff.window_boundary_byte, wwd_pkg::LOW_CLEAR});
		// R14: valid service
		svc_ok = svc_req && run_en && (st_ff.mode == wwd_pkg::WWD_RUN) && !in_window;
		win_bad = svc_req && run_en && (st_ff.mode == wwd_pkg::WWD_RUN) && in_window;
		// Service in the same cycle as the last count saves the system
		ovf = tick && (st_ff.mode == wwd_pkg::WWD_RUN) && !svc_req &&
			(st_ff.watchdog_counter == wwd_pkg::CNT_TOP);
		pw_done = tick && (st_ff.mode == wwd_pkg::WWD_PREWARN) && (st_ff.pw_cnt == PW_LAST);

		// Prescaler restarts on service so each period is exact
		// R10: exact period
		if (svc_ok || tick)
			nxt_st.pre = 7'h00;
		else if (run_en)
			nxt_st.pre = st_ff.pre + 7'h01;

		// Counter: low stage carries into high stage
		if (svc_ok)
		begin
			// R3: reload upper, clear lower
			// R4: restart from reload*256
			nxt_st.watchdog_counter = {st_ff.reload_high_byte, wwd_pkg::LOW_CLEAR};
		end
		else if (tick)
		begin
			// R1: chained stages
			nxt_st.watchdog_counter[7:0] = st_ff.watchdog_counter[7:0] + 8'h01;
			if (st_ff.watchdog_counter[7:0] == 8'hff)
				nxt_st.watchdog_counter[15:8] = st_ff.watchdog_counter[15:8] + 8'h01;
		end

		// Mode sequence
		unique case (st_ff.mode)
			wwd_pkg::WWD_RUN:
			begin
				if (ovf)
				begin
					// R5: timeout NMI
					nxt_st.mode = wwd_pkg::WWD_PREWARN;
					nxt_st.timeout_nmi_out = 1'b1;
					nxt_st.pw_cnt = 8'h00;
					evt_set[wwd_pkg::EVT_TIMEOUT_BIT] = 1'b1;
				end
				else if (win_bad)
				begin
					// R7: early service, no NMI
					// R9: window shortens period
					nxt_st.mode = wwd_pkg::WWD_PREWARN;
					nxt_st.pw_cnt = 8'h00;
					evt_set[wwd_pkg::EVT_WINDOW_BIT] = 1'b1;
				end
			end
			wwd_pkg::WWD_PREWARN:
			begin
				// R6: prewarning length
				if (pw_done)
				begin
					nxt_st.mode = wwd_pkg::WWD_SYSRST;
					nxt_st.system_reset_out = 1'b1;
					evt_set[wwd_pkg::EVT_SYSRST_BIT] = 1'b1;
				end
				else if (tick)
					nxt_st.pw_cnt = st_ff.pw_cnt + 8'h01;
			end
			wwd_pkg::WWD_SYSRST:
			begin
				// Held until the block itself is reset
				nxt_st.system_reset_out = 1'b1;
			end
			default:
			begin
				nxt_st.mode = wwd_pkg::WWD_SYSRST;
				nxt_st.system_reset_out = 1'b1;
			end
		endcase

		// Write channel capture, address and data in either order
		if (s_axi_awvalid && st_ff.awready)
		begin
			nxt_st.aw_got = 1'b1;
			nxt_st.aw_addr = aw8;
		end
		if (s_axi_wvalid && st_ff.wready)
		begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end

		// Register writes; config fields sit in byte lane 0
		if (wr_fire)
		begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = is_mapped(st_ff.aw_addr) ? wwd_pkg::RESP_OKAY : wwd_pkg::RESP_SLVERR;
			if (st_ff.wstrb[0])
			begin
				unique case (st_ff.aw_addr)
					wwd_pkg::OFF_CTRL:
					begin
						nxt_st.enable = st_ff.wdata[wwd_pkg::CTRL_ENABLE_BIT];
						nxt_st.count_prescale_select = st_ff.wdata[wwd_pkg::CTRL_PRESCALE_BIT];
						nxt_st.win_en = st_ff.wdata[wwd_pkg::CTRL_WIN_EN_BIT];
					end
					wwd_pkg::OFF_RELOAD: nxt_st.reload_high_byte = st_ff.wdata[7:0];
					wwd_pkg::OFF_WINDOW: nxt_st.window_boundary_byte = st_ff.wdata[7:0];
					wwd_pkg::OFF_IRQ_STAT: evt_clr = st_ff.wdata[2:0];
					wwd_pkg::OFF_IRQ_MASK: nxt_st.irq_mask = st_ff.wdata[2:0];
					default:
					begin
					end
				endcase
			end
		end
		if (st_ff.bvalid && s_axi_bready)
			nxt_st.bvalid = 1'b0;

		// Sticky events: a set in the clearing cycle survives
		nxt_st.irq_stat = (st_ff.irq_stat & ~evt_clr) | evt_set;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

		// Read channel: one access at a time
		if (s_axi_arvalid && st_ff.arready)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = is_mapped(ar8) ? wwd_pkg::RESP_OKAY : wwd_pkg::RESP_SLVERR;
			nxt_st.rdata = 32'h0000_0000;
			unique case (ar8)
				wwd_pkg::OFF_CTRL:
				begin
					nxt_st.rdata[wwd_pkg::CTRL_ENABLE_BIT] = st_ff.enable;
					nxt_st.rdata[wwd_pkg::CTRL_PRESCALE_BIT] = st_ff.count_prescale_select;
					nxt_st.rdata[wwd_pkg::CTRL_WIN_EN_BIT] = st_ff.win_en;
				end
				wwd_pkg::OFF_RELOAD: nxt_st.rdata[7:0] = st_ff.reload_high_byte;
				wwd_pkg::OFF_WINDOW: nxt_st.rdata[7:0] = st_ff.window_boundary_byte;
				wwd_pkg::OFF_COUNT: nxt_st.rdata[15:0] = st_ff.watchdog_counter;
				wwd_pkg::OFF_STATUS:
				begin
					nxt_st.rdata[wwd_pkg::STAT_PREWARN_BIT] = (st_ff.mode == wwd_pkg::WWD_PREWARN);
					nxt_st.rdata[wwd_pkg::STAT_NMI_BIT] = st_ff.timeout_nmi_out;
					nxt_st.rdata[wwd_pkg::STAT_SYSRST_BIT] = st_ff.system_reset_out;
					nxt_st.rdata[wwd_pkg::STAT_PWCNT_LSB +: 8] = st_ff.pw_cnt;
				end
				wwd_pkg::OFF_IRQ_STAT: nxt_st.rdata[2:0] = st_ff.irq_stat;
				wwd_pkg::OFF_IRQ_MASK: nxt_st.rdata[2:0] = st_ff.irq_mask;
				default:
				begin
				end
			endcase
		end
		else if (st_ff.rvalid && s_axi_rready)
			nxt_st.rvalid = 1'b0;

		// Readies drop while a channel holds an item or a reply waits
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;
		nxt_st.arready = !nxt_st.rvalid;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// All-zero reset: run mode, disabled, readies rise one edge later
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rresp = st_ff.rresp;
	assign s_axi_rdata = st_ff.rdata;
	assign timeout_nmi_out = st_ff.timeout_nmi_out;
	assign system_reset_out = st_ff.system_reset_out;
	assign irq = st_ff.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CHAIN_CARRY: assert property (tick && !svc_ok && st_ff.watchdog_counter[7:0] == 8'hff // R1
		|=> st_ff.watchdog_counter[15:8] == $past(st_ff.watchdog_counter[15:8]) + 8'h01)
		else $error("High stage missed the carry");
	AST_FAST_RATE: assert property (tick && !st_ff.count_prescale_select && run_en // R2
		##1 (run_en && !svc_ok && !st_ff.count_prescale_select)
		|-> !tick ##1 (!run_en || tick || svc_ok || st_ff.count_prescale_select))
		else $error("Fast prescale is not two cycles");
	AST_SERVICE_LOAD: assert property (svc_ok // R3
		|=> st_ff.watchdog_counter == {$past(st_ff.reload_high_byte), 8'h00} && st_ff.pre == 7'h00)
		else $error("Service did not load reload byte");
	AST_TIMEOUT: assert property (ovf // R5
		|=> timeout_nmi_out && st_ff.mode == wwd_pkg::WWD_PREWARN && st_ff.irq_stat[0])
		else $error("Overflow did not raise timeout");
	AST_PREWARN_END: assert property (pw_done // R6
		|=> system_reset_out && st_ff.mode == wwd_pkg::WWD_SYSRST)
		else $error("Prewarning end did not reset");
	AST_WINDOW_BAD: assert property (win_bad // R7
		|=> st_ff.mode == wwd_pkg::WWD_PREWARN && !timeout_nmi_out && st_ff.pw_cnt == 8'h00)
		else $error("Window violation handled wrongly");
	AST_DEBUG_HOLD: assert property (debug_mode // R11
		|=> $stable(st_ff.watchdog_counter) && $stable(st_ff.mode) && $stable(st_ff.pw_cnt))
		else $error("Watchdog moved in debug mode");
	AST_VALID_SERVICE: assert property (svc_ok // R14
		|=> st_ff.mode == wwd_pkg::WWD_RUN && !timeout_nmi_out)
		else $error("Valid service started prewarning");
	AST_RESET_STICKS: assert property (system_reset_out |=> system_reset_out[*2]) // R6
		else $error("System reset dropped");
	AST_IRQ_LEVEL: assert property (irq == |(st_ff.irq_stat & st_ff.irq_mask))
		else $error("Interrupt level disagrees with status");

	COV_SERVICE: cover property (svc_ok);
	COV_OVERFLOW_TO_RESET: cover property (ovf ##[1:300] system_reset_out);
	COV_WINDOW_BAD: cover property (win_bad);
	COV_DEBUG_PAUSE: cover property (debug_mode[*3] ##1 !debug_mode ##1 run_en);

endmodule

// >>> sim/wwd_cpu_model.sv
// CPU side of the register bus: one write and one read at a time
module wwd_cpu_model (
	// Clock
	input wire logic aclk,
	// Write address and data
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	// Write response
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus; response readies stay high, which the bus allows
	initial
	begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1;
	end

	// one write per service
	// Released payload is inverted so a stale value is never mistaken for a live one
	// Waits as long as the slave needs; only the bench watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				{s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~s_axi_awaddr};
			if (s_axi_wvalid && s_axi_wready)
				{s_axi_wvalid, s_axi_wdata} <= {1'b0, ~s_axi_wdata};
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask

	// Read one word, data taken at the edge that shows rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				{s_axi_arvalid, s_axi_araddr} <= {1'b0, ~s_axi_araddr};
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule

// >>> sim/wwd_top_bench.sv
module wwd_top_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// Short prewarning keeps each run brief
	localparam int PW = 2;
	logic aclk, aresetn, debug_mode, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic timeout_nmi_out, system_reset_out, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors, cmp_count;

	wwd_top #(.ADDR_W(8), .PW_COUNTS(PW)) u_wwd_top (.*);
	wwd_cpu_model u_wwd_cpu_model (.*);

	// 10 MHz clock
	always #50 aclk = ~aclk;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_wwd_cpu_model.wr(a, d, r);
		chk({30'h0, r}, {30'h0, wwd_pkg::RESP_OKAY});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		u_wwd_cpu_model.rd(a, d, r);
		chk(d & m, e);
	endtask

	// Reset held for two cycles, debug off
	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		debug_mode <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		do_reset();
		rd(wwd_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
		rd(wwd_pkg::OFF_COUNT, 32'hffffffff, 32'h0);
		u_wwd_cpu_model.rd(8'h20, d, r);
		chk({30'h0, r}, {30'h0, wwd_pkg::RESP_SLVERR});
		chk(d, 32'h0);
		u_wwd_cpu_model.wr(8'h24, 32'h1, r);
		chk({30'h0, r}, {30'h0, wwd_pkg::RESP_SLVERR});
	endtask

	// Overflow timing at /2 with reload ff: 512 cycles after service
	task automatic t_overflow();
		do_reset();
		wr(wwd_pkg::OFF_RELOAD, 32'hff);
		wr(wwd_pkg::OFF_IRQ_MASK, 32'h7);
		wr(wwd_pkg::OFF_CTRL, 32'h1);
		wr(wwd_pkg::OFF_SERVICE, 32'h1);
		repeat (505) @(posedge aclk);
		chk_bit(timeout_nmi_out, 1'b0);
		repeat (10) @(posedge aclk);
		chk_bit(timeout_nmi_out, 1'b1);
		repeat (10) @(posedge aclk);
		chk_bit(system_reset_out, 1'b1);
		chk_bit(irq, 1'b1);
		rd(wwd_pkg::OFF_IRQ_STAT, 32'hffffffff, 32'h5);
		wr(wwd_pkg::OFF_IRQ_STAT, 32'h5);
		chk_bit(irq, 1'b0);
		chk_bit(timeout_nmi_out, 1'b1);
	endtask

	// Slow rate: 128 * 256 cycles to overflow
	task automatic t_slow();
		do_reset();
		wr(wwd_pkg::OFF_RELOAD, 32'hff);
		wr(wwd_pkg::OFF_CTRL, 32'h3);
		wr(wwd_pkg::OFF_SERVICE, 32'h1);
		repeat (32760) @(posedge aclk);
		chk_bit(timeout_nmi_out, 1'b0);
		repeat (20) @(posedge aclk);
		chk_bit(timeout_nmi_out, 1'b1);
	endtask

	// Early service inside the window, event masked at first
	task automatic t_window();
		do_reset();
		wr(wwd_pkg::OFF_RELOAD, 32'h80);
		wr(wwd_pkg::OFF_WINDOW, 32'h90);
		wr(wwd_pkg::OFF_CTRL, 32'h5);
		wr(wwd_pkg::OFF_SERVICE, 32'h1);
		repeat (10) @(posedge aclk);
		chk_bit(timeout_nmi_out, 1'b0);
		chk_bit(system_reset_out, 1'b1);
		chk_bit(irq, 1'b0);
		rd(wwd_pkg::OFF_STATUS, 32'h7, 32'h4);
		rd(wwd_pkg::OFF_IRQ_STAT, 32'hffffffff, 32'h6);
		wr(wwd_pkg::OFF_IRQ_MASK, 32'h2);
		chk_bit(irq, 1'b1);
	endtask

	// Service above the window is accepted and reloads; the wait lets the
	// count climb well past 8000 so a missed reload shows in the read
	task automatic t_valid();
		do_reset();
		wr(wwd_pkg::OFF_RELOAD, 32'h80);
		wr(wwd_pkg::OFF_WINDOW, 32'h80);
		wr(wwd_pkg::OFF_CTRL, 32'h1);
		wr(wwd_pkg::OFF_SERVICE, 32'h1);
		wr(wwd_pkg::OFF_CTRL, 32'h5);
		repeat (100) @(posedge aclk);
		wr(wwd_pkg::OFF_SERVICE, 32'h1);
		rd(wwd_pkg::OFF_COUNT, 32'hfff0, 32'h8000);
		rd(wwd_pkg::OFF_STATUS, 32'h7, 32'h0);
		rd(wwd_pkg::OFF_IRQ_STAT, 32'h7, 32'h0);
	endtask

	// Debug freezes the count; release lets the overflow come
	// Freeze lands before the first tick after the service, so ff00 holds
	task automatic t_debug();
		do_reset();
		wr(wwd_pkg::OFF_RELOAD, 32'hff);
		wr(wwd_pkg::OFF_CTRL, 32'h1);
		wr(wwd_pkg::OFF_SERVICE, 32'h1);
		debug_mode <= 1'b1;
		rd(wwd_pkg::OFF_COUNT, 32'hffffffff, 32'hff00);
		repeat (1000) @(posedge aclk);
		rd(wwd_pkg::OFF_COUNT, 32'hffffffff, 32'hff00);
		chk_bit(timeout_nmi_out, 1'b0);
		debug_mode <= 1'b0;
		repeat (600) @(posedge aclk);
		chk_bit(timeout_nmi_out, 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		debug_mode = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		t_regs();
		t_overflow();
		t_slow();
		t_window();
		t_valid();
		t_debug();
		give_verdict();
	end

	// Whole run needs about 35000 cycles
	initial
	begin
		repeat (60000) @(posedge aclk);
		num_errors++;
		give_verdict();
	end
endmodule
